/* File: shared/tpioc_pkg.sv */
// Package: register map, field layout and encodings for channel 2 pin I/O control
package tpioc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_IO_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PIN_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CAP_STAT = 4'h8;
  localparam logic [7:0] IO_CTRL_RESET = 8'h00;
  localparam int unsigned FLD_B_LSB = 4;
  localparam int unsigned FLD_A_LSB = 0;
  localparam int unsigned FLD_W = 4;
  localparam int unsigned FB_CAPTURE = 3;
  localparam int unsigned FB_LEVEL = 2;
  localparam int unsigned CNT_W = 16;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_ACK = 3'h2,
    BUS_DONE = 3'h4
  } tpioc_bus_state_t;
endpackage

/* File: shared/tpioc_pin_if.sv */
// Interface: one pin field, its pin sample and its strobes
`timescale 1ns/100ps
interface tpioc_pin_if;
  logic [3:0] field;
  logic cfg_wr;
  logic pin_in;
  logic match;
  logic pin_out;
  logic pin_oe_n;
  logic capture;
  modport ctrl (output field, output cfg_wr, output pin_in, output match,
                input pin_out, input pin_oe_n, input capture);
  modport pin (input field, input cfg_wr, input pin_in, input match,
               output pin_out, output pin_oe_n, output capture);
endinterface

/* File: hw/tpioc_pin.sv */
// One pin function unit: compare output drive or capture edge detection
`timescale 1ns/100ps
module tpioc_pin (
  input wire logic mclk_i,
  input wire logic nrst_i,
  tpioc_pin_if.pin p
);
  logic cap_mode;
  logic pin_prev_q;
  logic pin_prev_d;
  logic out_q;
  logic out_d;
  logic oen_q;
  logic oen_d;
  logic cap_q;
  logic cap_d;

  assign cap_mode = p.field[tpioc_pkg::FB_CAPTURE];

  always_comb begin
    pin_prev_d = p.pin_in;
    out_d = out_q;
    oen_d = oen_q;
    cap_d = 1'b0;
    if (cap_mode) begin
      oen_d = 1'b1;
      if (p.field[1]) begin
        cap_d = p.pin_in ^ pin_prev_q; // RULE5
      end else if (p.field[0]) begin
        cap_d = pin_prev_q & ~p.pin_in; // RULE4
      end else begin
        cap_d = ~pin_prev_q & p.pin_in; // RULE3
      end
    end else if (p.field[1:0] == tpioc_pkg::ACT_NONE) begin
      oen_d = 1'b1; // RULE7
    end else begin
      oen_d = 1'b0;
      if (p.cfg_wr) begin
        // Level loads on each write, so a new mode starts clean
        out_d = p.field[tpioc_pkg::FB_LEVEL]; // RULE8 RULE9
      end else if (p.match) begin
        case (p.field[1:0])
          tpioc_pkg::ACT_LOW: out_d = 1'b0; // RULE10
          tpioc_pkg::ACT_HIGH: out_d = 1'b1; // RULE11
          default: out_d = ~out_q; // RULE12
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_prev_q <= 1'b0;
      out_q <= 1'b0;
      oen_q <= 1'b1;
      cap_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_prev_d;
      out_q <= out_d;
      oen_q <= oen_d;
      cap_q <= cap_d;
    end
  end

  assign p.pin_out = out_q;
  assign p.pin_oe_n = oen_q;
  assign p.capture = cap_q;
endmodule

/* File: hw/tpioc_top.sv */
// Top: channel 2 pin I/O control register, Avalon-MM slave, two pin units
//
// Contract
// RULE1: Bits 7..4 steer pin B and register B, bit 7 set makes B capture from pin B, bit 6 ignored.
// RULE2: Bits 3..0 steer pin A and register A, bit 3 set makes A capture from pin A, bit 2 ignored.
// RULE3: Capture with low bits 00 loads the counter on each rising pin edge.
// RULE4: Capture with low bits 01 loads the counter on each falling pin edge.
// RULE5: Capture with bit 1 set loads the counter on both pin edges.
// RULE6: The A field uses the same edge coding as the B field, sourced from pin A.
// RULE7: Compare mode with low bits 00 leaves the pin undriven.
// RULE8: Compare mode with output on and level bit 0 starts the pin low.
// RULE9: Compare mode with output on and level bit 1 starts the pin high.
// RULE10: Compare mode low bits 01 drives the pin low on match.
// RULE11: Compare mode low bits 10 drives the pin high on match.
// RULE12: Compare mode low bits 11 toggles the pin on match.
`timescale 1ns/100ps
module tpioc_top (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [tpioc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [tpioc_pkg::CNT_W-1:0] counter_i,
  input wire logic match_a_i,
  input wire logic match_b_i,
  input wire logic chan2_pin_a_i,
  input wire logic chan2_pin_b_i,
  output logic chan2_pin_a_o,
  output logic chan2_pin_a_oe_n_o,
  output logic chan2_pin_b_o,
  output logic chan2_pin_b_oe_n_o,
  output logic capture_a_o,
  output logic capture_b_o,
  output logic [tpioc_pkg::CNT_W-1:0] chan2_general_reg_a_o,
  output logic [tpioc_pkg::CNT_W-1:0] chan2_general_reg_b_o
);
  // ----------------------------------------
  // Register and bus state
  // ----------------------------------------
  tpioc_pkg::tpioc_bus_state_t st_q;
  tpioc_pkg::tpioc_bus_state_t st_d;
  logic wait_q;
  logic wait_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic wr_q;
  logic wr_d;
  logic [1:0] seen_q;
  logic [1:0] seen_d;
  logic [tpioc_pkg::CNT_W-1:0] gra_q;
  logic [tpioc_pkg::CNT_W-1:0] gra_d;
  logic [tpioc_pkg::CNT_W-1:0] grb_q;
  logic [tpioc_pkg::CNT_W-1:0] grb_d;
  logic req;
  logic take;
  logic [2:0] sel;
  logic [1:0] pin_in;
  logic [1:0] match;

  // Index 0 carries pin A, index 1 pin B
  tpioc_pin_if pif [0:1] ();

  // ----------------------------------------
  // Address decoding
  // ----------------------------------------
  // One decoder for read mux, write path and read-to-clear
  function automatic logic [2:0] reg_sel(input logic [tpioc_pkg::ADDR_W-1:0] addr);
    logic [2:0] hit;
    hit = 3'h0;
    if (addr == tpioc_pkg::OFS_IO_CTRL) begin
      hit[0] = 1'b1;
    end else if (addr == tpioc_pkg::OFS_PIN_STAT) begin
      hit[1] = 1'b1;
    end else if (addr == tpioc_pkg::OFS_CAP_STAT) begin
      hit[2] = 1'b1;
    end
    return hit;
  endfunction

  assign req = avs_read_i | avs_write_i;
  // Taken only from idle, so a held request counts once
  assign take = req && (st_q == tpioc_pkg::BUS_IDLE);
  assign sel = reg_sel(avs_address_i);

  // ----------------------------------------
  // Pin units
  // ----------------------------------------
  assign pin_in = {chan2_pin_b_i, chan2_pin_a_i};
  assign match = {match_b_i, match_a_i};

  for (genvar i = 0; i < 2; i++) begin : g_pin
    localparam int unsigned LSB = (i == 0) ? tpioc_pkg::FLD_A_LSB : tpioc_pkg::FLD_B_LSB;
    assign pif[i].field = ctrl_q[LSB +: tpioc_pkg::FLD_W]; // RULE1 RULE2 RULE6
    assign pif[i].cfg_wr = wr_q;
    assign pif[i].pin_in = pin_in[i];
    assign pif[i].match = match[i];

    tpioc_pin u_pin (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .p(pif[i].pin)
    );
  end

  // ----------------------------------------
  // Avalon-MM slave: one wait state per access
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      tpioc_pkg::BUS_IDLE: begin
        if (req) begin
          st_d = tpioc_pkg::BUS_ACK;
        end
      end
      tpioc_pkg::BUS_ACK: begin
        st_d = tpioc_pkg::BUS_DONE;
      end
      default: begin
        st_d = tpioc_pkg::BUS_IDLE;
      end
    endcase
    // Registered so the pin comes straight from a flop
    wait_d = (st_d != tpioc_pkg::BUS_ACK);
    rd_d = rd_q;
    if (take && !avs_write_i) begin
      if (sel[0]) begin
        rd_d = {24'h0, ctrl_q};
      end else if (sel[1]) begin
        rd_d = {26'h0, chan2_pin_b_i, chan2_pin_a_i,
                pif[1].pin_oe_n, pif[1].pin_out, pif[0].pin_oe_n, pif[0].pin_out};
      end else if (sel[2]) begin
        rd_d = {30'h0, seen_q};
      end else begin
        rd_d = tpioc_pkg::RD_UNMAPPED;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= tpioc_pkg::BUS_IDLE;
      wait_q <= 1'b1;
      rd_q <= 32'h0;
    end else begin
      st_q <= st_d;
      wait_q <= wait_d;
      rd_q <= rd_d;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Lane 0 alone holds the byte; other lanes are dropped
  always_comb begin
    ctrl_d = ctrl_q;
    wr_d = 1'b0;
    if (take && avs_write_i && sel[0] && avs_byteenable_i[0]) begin
      ctrl_d = avs_writedata_i[7:0];
      wr_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= tpioc_pkg::IO_CTRL_RESET;
      wr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      wr_q <= wr_d;
    end
  end

  // ----------------------------------------
  // Captured counter values
  // ----------------------------------------
  always_comb begin
    gra_d = gra_q;
    grb_d = grb_q;
    seen_d = seen_q;
    // Capture set wins over a read-to-clear in the same cycle
    if (take && avs_read_i && sel[2]) begin
      seen_d = 2'h0;
    end
    if (pif[0].capture) begin
      gra_d = counter_i; // RULE2 RULE3 RULE4 RULE5 RULE6
      seen_d[0] = 1'b1;
    end
    if (pif[1].capture) begin
      grb_d = counter_i; // RULE1 RULE3 RULE4 RULE5
      seen_d[1] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seen_q <= 2'h0;
      gra_q <= '0;
      grb_q <= '0;
    end else begin
      seen_q <= seen_d;
      gra_q <= gra_d;
      grb_q <= grb_d;
    end
  end

  // ----------------------------------------
  // Outputs, all registered
  // ----------------------------------------
  assign avs_readdata_o = rd_q;
  assign avs_waitrequest_o = wait_q;
  assign chan2_pin_a_o = pif[0].pin_out;
  assign chan2_pin_a_oe_n_o = pif[0].pin_oe_n;
  assign chan2_pin_b_o = pif[1].pin_out;
  assign chan2_pin_b_oe_n_o = pif[1].pin_oe_n;
  assign capture_a_o = pif[0].capture;
  assign capture_b_o = pif[1].capture;
  assign chan2_general_reg_a_o = gra_q;
  assign chan2_general_reg_b_o = grb_q;
endmodule

/* File: tb/tpioc_pins.sv */
// Far side: outside drivers sharing the channel 2 pins
`timescale 1ns/100ps
module tpioc_pins (
  input wire logic drv_i,
  input wire logic chan2_pin_a_o,
  input wire logic chan2_pin_a_oe_n_o,
  input wire logic chan2_pin_b_o,
  input wire logic chan2_pin_b_oe_n_o,
  output logic chan2_pin_a_i,
  output logic chan2_pin_b_i
);
  // Device wins while driving, else the outside source
  assign chan2_pin_a_i = chan2_pin_a_oe_n_o ? drv_i : chan2_pin_a_o;
  assign chan2_pin_b_i = chan2_pin_b_oe_n_o ? drv_i : chan2_pin_b_o;
endmodule

/* File: tb/tpioc_top_checker.sv */
// Checker: pin mode assertions for channel 2 pin control
`timescale 1ns/100ps
module tpioc_top_checker (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [tpioc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  input wire logic match_a_i,
  input wire logic match_b_i,
  input wire logic chan2_pin_a_i,
  input wire logic chan2_pin_a_o,
  input wire logic chan2_pin_a_oe_n_o,
  input wire logic chan2_pin_b_o,
  input wire logic chan2_pin_b_oe_n_o,
  input wire logic chan2_pin_b_i,
  input wire logic capture_a_o,
  input wire logic capture_b_o
);
  logic [7:0] f_q, f_d;
  logic [1:0] n_q, n_d;
  logic w, ok;
  // Shadow byte; checks wait 3 cycles so new levels land
  assign w = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
             && avs_address_i == tpioc_pkg::OFS_IO_CTRL;
  assign ok = n_q == 2'h3 && !w;
  always_comb begin
    f_d = w ? avs_writedata_i[7:0] : f_q;
    n_d = w ? 2'h0 : n_q + 2'(n_q != 2'h3);
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      f_q <= tpioc_pkg::IO_CTRL_RESET;
      n_q <= 2'h3;
    end else begin
      f_q <= f_d;
      n_q <= n_d;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_cap_undriven: assert property (ok |-> (!f_q[7] || chan2_pin_b_oe_n_o)
    && (!f_q[3] || chan2_pin_a_oe_n_o)) else $error("pin driven in capture");
  a_rise_cap: assert property (ok && f_q[3] && f_q[1:0] == 2'h0
    && $rose(chan2_pin_a_i) |-> ##[1:2] capture_a_o) else $error("rise missed");
  a_fall_cap: assert property (ok && f_q[3] && f_q[1:0] == 2'h1
    && $fell(chan2_pin_a_i) |-> ##[1:2] capture_a_o) else $error("fall missed");
  a_both_cap: assert property (ok && f_q[3] && f_q[1]
    && $changed(chan2_pin_a_i) |-> ##[1:2] capture_a_o) else $error("edge missed");
  a_out_off: assert property (ok && !f_q[3] && f_q[1:0] == 2'h0
    |-> chan2_pin_a_oe_n_o) else $error("disabled pin driven");
  a_out_on: assert property (ok && !f_q[7] && f_q[5:4] != 2'h0
    |-> !chan2_pin_b_oe_n_o) else $error("enabled pin idle");
  a_match_low: assert property (ok && !f_q[3] && f_q[1:0] == 2'h1
    && match_a_i |=> !chan2_pin_a_o) else $error("no low");
  a_match_high: assert property (ok && !f_q[7] && f_q[5:4] == 2'h2
    && match_b_i |=> chan2_pin_b_o) else $error("no high");
  a_match_toggle: assert property (ok && !f_q[3] && f_q[1:0] == 2'h3
    && match_a_i |=> chan2_pin_a_o != $past(chan2_pin_a_o)) else $error("no toggle");
  a_b_edge_cap: assert property (ok && f_q[7] && f_q[5]
    && $changed(chan2_pin_b_i) |-> ##[1:2] capture_b_o) else $error("pin b edge missed");
endmodule

/* File: tb/tpioc_top_test.sv */
// Testbench: register, compare and capture checks for channel 2 pins
`timescale 1ns/100ps
module tpioc_top_test;
  logic mclk_i = 1'h0, nrst_i = 1'h0, avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic match_a_i = 1'h0, match_b_i = 1'h0, drv_i = 1'h0, avs_waitrequest_o;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [15:0] counter_i = 16'h0, chan2_general_reg_a_o, chan2_general_reg_b_o;
  logic chan2_pin_a_i, chan2_pin_b_i, chan2_pin_a_o, chan2_pin_a_oe_n_o;
  logic chan2_pin_b_o, chan2_pin_b_oe_n_o, capture_a_o, capture_b_o;
  int n_fail = 0, tests_run = 0, ea = 0, c;
  int la = 0, lb = 0, ps;
  always #20 mclk_i = ~mclk_i;
  tpioc_top uut (.*);
  tpioc_pins pins (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d fails %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Slave latency is not assumed; a hung slave ends the run
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i = 0;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge mclk_i);
      i++;
    end while (avs_waitrequest_o !== 1'h0 && i < 20);
    if (avs_waitrequest_o !== 1'h0) begin
      n_fail++;
      end_of_test();
    end
    q = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    @(posedge mclk_i);
  endtask
  function automatic int lvl(int f, int m);
    if (m == 0 || f % 4 == 3) return (f / 4 + m) % 2;
    return f % 4 == 2;
  endfunction
  task automatic pc(input logic oe, input logic p, input int f, input int m);
    chk(oe, f % 4 == 0);
    if (f % 4 != 0) chk(p, lvl(f, m));
  endtask
  initial begin
    void'($urandom(12));
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'h1;
    @(posedge mclk_i);
    bus(1'h0, tpioc_pkg::OFS_IO_CTRL, 32'h0);
    chk(q, tpioc_pkg::IO_CTRL_RESET);
    bus(1'h0, 4'hC, 32'h0);
    chk(q, tpioc_pkg::RD_UNMAPPED);
    avs_byteenable_i <= 4'h0;
    bus(1'h1, tpioc_pkg::OFS_IO_CTRL, 32'h33);
    avs_byteenable_i <= 4'hF;
    bus(1'h0, tpioc_pkg::OFS_IO_CTRL, 32'h0);
    chk(q, 32'h0);
    for (int f = 0; f < 8; f++) begin
      bus(1'h1, tpioc_pkg::OFS_IO_CTRL, 32'((7 - f) * 16 + f));
      bus(1'h0, tpioc_pkg::OFS_IO_CTRL, 32'h0);
      chk(q, (7 - f) * 16 + f);
      pc(chan2_pin_a_oe_n_o, chan2_pin_a_o, f, 0);
      pc(chan2_pin_b_oe_n_o, chan2_pin_b_o, 7 - f, 0);
      c = 1 + $urandom % 3;
      match_a_i <= 1'h1;
      match_b_i <= 1'h1;
      repeat (c) @(posedge mclk_i);
      match_a_i <= 1'h0;
      match_b_i <= 1'h0;
      @(posedge mclk_i);
      pc(chan2_pin_a_oe_n_o, chan2_pin_a_o, f, c);
      pc(chan2_pin_b_oe_n_o, chan2_pin_b_o, 7 - f, c);
      // Disabled pins keep their last level and show the outside driver
      if (f % 4 != 0) la = lvl(f, c);
      if ((7 - f) % 4 != 0) lb = lvl(7 - f, c);
      ps = ((7 - f) % 4 != 0 && lb != 0) * 32 + (f % 4 != 0 && la != 0) * 16;
      ps += ((7 - f) % 4 == 0) * 8 + lb * 4 + (f % 4 == 0) * 2 + la;
      bus(1'h0, tpioc_pkg::OFS_PIN_STAT, 32'h0);
      chk(q, ps);
    end
    for (int e = 3; e >= 0; e--) begin
      bus(1'h1, tpioc_pkg::OFS_IO_CTRL, 32'(136 + e * 17 + $urandom % 2 * 68));
      repeat (3) @(posedge mclk_i);
      for (int v = 1; v >= 0; v--) begin
        c = $urandom % 65536;
        counter_i <= 16'(c);
        @(posedge mclk_i);
        drv_i <= v[0];
        repeat (4) @(posedge mclk_i);
        if (e > 1 || e == 1 - v) ea = c;
        chk(chan2_general_reg_a_o, ea);
        chk(chan2_general_reg_b_o, ea);
      end
    end
    bus(1'h0, tpioc_pkg::OFS_CAP_STAT, 32'h0);
    chk(q, 32'h3);
    bus(1'h0, tpioc_pkg::OFS_CAP_STAT, 32'h0);
    chk(q, 32'h0);
    end_of_test();
  end
endmodule
bind tpioc_top tpioc_top_checker chk_u (.*);
